// [hw/sfp_core.v]
// Fault detect, low-power handling and event flags of a serial port.
// Assumes a shift engine on core_clk that moves words and reports done.
`include "sfp_regs.vh"
`timescale 1ns/1ps

module sfp_core #(
  parameter DATA_W = `SFP_DATA_W,
  parameter BYTE_W = `SFP_BYTE_W
) (
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // Pins from the far party, asynchronous
  input wire select_n_pin,
  input wire serial_clock_pin,
  // Configuration levels
  input wire system_enable,
  input wire mode_fault_enable,
  input wire select_output_enable,
  input wire single_wire_select,
  input wire sixteen_bit_mode,
  input wire stop_in_wait,
  input wire rx_fault_irq_mask,
  input wire tx_irq_mask,
  input wire match_irq_mask,
  input wire [DATA_W-1:0] match_value,
  // Processor power state
  input wire cpu_wait,
  input wire cpu_stop3,
  input wire cpu_stop_other,
  // Software access strobes
  input wire status_rd,
  input wire ctl1_wr,
  input wire ctl1_master_select,
  input wire ctl2_shared_oe,
  input wire data_rd,
  input wire data_wr,
  input wire [DATA_W-1:0] data_wr_value,
  input wire match_clr,
  // Shift engine side
  input wire shifter_done,
  input wire [DATA_W-1:0] shifter_rx_data,
  input wire tx_out_ready,
  // Status and data
  output reg mode_fault_flag_q,
  output reg rx_full_flag_q,
  output reg tx_empty_flag_q,
  output reg match_flag_q,
  output reg master_select_q,
  output reg shared_pin_output_enable_q,
  output reg [DATA_W-1:0] rx_data_q,
  output reg irq_q,
  // Transmit buffer
  output reg tx_in_ready_q,
  output reg tx_out_valid_q,
  output reg [DATA_W-1:0] tx_out_data_q,
  // Engine control
  output reg core_run_q,
  output reg abort_q,
  output reg tx_hold_q,
  // Pin output enables
  output reg serial_clock_oe_q,
  output reg master_out_oe_q,
  output reg slave_out_oe_q
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg sel_m_q; // First stage, only read by second
  reg sel_s_q; // Synchronised select, active low
  reg sck_m_q;
  reg sck_s_q;
  reg sck_d1_q; // Previous sampled link clock, for edges
  wire sck_edge;

  // Two stages on each pin so metastability never reaches logic
  always @(posedge core_clk) begin
    if (srst) begin
      sel_m_q <= 1'b1;
      sel_s_q <= 1'b1;
      sck_m_q <= 1'b0;
      sck_s_q <= 1'b0;
      sck_d1_q <= 1'b0;
    end else begin
      sel_m_q <= select_n_pin;
      sel_s_q <= sel_m_q;
      sck_m_q <= serial_clock_pin;
      sck_s_q <= sck_m_q;
      sck_d1_q <= sck_s_q;
    end
  end

  assign sck_edge = sck_s_q ^ sck_d1_q;

  // ----------------------------------------------------------------
  // Low-power state and soft reset
  // ----------------------------------------------------------------
  reg [2:0] lp_q; // One-hot power state
  reg [2:0] lp_d;
  wire doze_req; // Wait with stop_in_wait set
  wire kill; // Reset clears everything; a deep stop all but the pin synchronisers

  assign doze_req = cpu_wait & stop_in_wait;
  // Deep stop holds reset for its whole length, so exit is clean
  assign kill = srst | cpu_stop_other;

  // Wait without stop_in_wait stays in run
  always @* begin
    case (lp_q)
      `SFP_LP_RUN: begin
        if (cpu_stop3) begin
          lp_d = `SFP_LP_FROZEN;
        end else if (doze_req) begin
          lp_d = `SFP_LP_DOZE;
        end else begin
          lp_d = `SFP_LP_RUN;
        end
      end
      `SFP_LP_DOZE: begin
        if (cpu_stop3) begin
          lp_d = `SFP_LP_FROZEN;
        end else if (doze_req) begin
          lp_d = `SFP_LP_DOZE;
        end else begin
          lp_d = `SFP_LP_RUN;
        end
      end
      `SFP_LP_FROZEN: begin
        // Stop3 ignores stop_in_wait entirely
        if (cpu_stop3) begin
          lp_d = `SFP_LP_FROZEN;
        end else begin
          lp_d = `SFP_LP_RUN;
        end
      end
      default: begin
        lp_d = `SFP_LP_RUN;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (kill) begin
      lp_q <= `SFP_LP_RUN;
    end else begin
      lp_q <= lp_d;
    end
  end

  wire lp_low; // Any low-power stay
  wire lp_exit;
  assign lp_low = (lp_q != `SFP_LP_RUN);
  assign lp_exit = lp_low & (lp_d == `SFP_LP_RUN);

  // ----------------------------------------------------------------
  // Slave transfer tracking from link clock edges
  // ----------------------------------------------------------------
  reg slave_busy_q; // A slave word is between first edge and done
  reg busy_at_entry_q; // Transfer was running when low power began
  reg defer_q; // A received word waits for low-power exit
  reg [DATA_W-1:0] defer_data_q;

  always @(posedge core_clk) begin
    if (kill) begin
      slave_busy_q <= 1'b0;
    end else if (shifter_done | master_select_q | sel_s_q) begin
      slave_busy_q <= 1'b0;
    end else if (sck_edge) begin
      slave_busy_q <= 1'b1;
    end
  end

  // Idle-to-idle stays never produce a copy
  always @(posedge core_clk) begin
    if (kill) begin
      busy_at_entry_q <= 1'b0;
      defer_q <= 1'b0;
      defer_data_q <= `SFP_RST_DATA;
    end else begin
      if (!lp_low && lp_d != `SFP_LP_RUN) begin
        busy_at_entry_q <= slave_busy_q;
      end
      if (lp_low && shifter_done && !master_select_q && busy_at_entry_q) begin
        defer_q <= 1'b1;
        defer_data_q <= shifter_rx_data;
      end else if (lp_exit) begin
        defer_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode fault detection and master select
  // ----------------------------------------------------------------
  wire fault_watch; // Detection armed
  wire fault_hit;
  reg fault_arm_q; // Status read seen with fault set

  // Only a master with detection on and auto select off watches
  assign fault_watch = master_select_q & mode_fault_enable & ~select_output_enable;
  assign fault_hit = fault_watch & system_enable & ~sel_s_q;

  // Hardware set outranks a clear in the same cycle
  always @(posedge core_clk) begin
    if (kill) begin
      mode_fault_flag_q <= `SFP_RST_FLAG;
      fault_arm_q <= 1'b0;
      master_select_q <= `SFP_RST_MASTER;
      shared_pin_output_enable_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      abort_q <= fault_hit;
      if (status_rd && mode_fault_flag_q) begin
        fault_arm_q <= 1'b1;
      end else if (ctl1_wr) begin
        fault_arm_q <= 1'b0;
      end
      if (fault_hit) begin
        mode_fault_flag_q <= 1'b1;
      end else if (ctl1_wr && fault_arm_q) begin
        mode_fault_flag_q <= 1'b0;
      end else if (master_select_q && !mode_fault_enable) begin
        mode_fault_flag_q <= 1'b0;
      end
      if (fault_hit) begin
        master_select_q <= 1'b0;
        if (single_wire_select) begin
          shared_pin_output_enable_q <= 1'b0;
        end
      end else if (ctl1_wr) begin
        master_select_q <= ctl1_master_select;
        shared_pin_output_enable_q <= ctl2_shared_oe;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers and engine control
  // ----------------------------------------------------------------
  wire dir_ok; // Data pin may drive in this wiring
  assign dir_ok = ~single_wire_select | shared_pin_output_enable_q;

  // Registered so every pin enable changes on a clock edge
  always @(posedge core_clk) begin
    if (kill) begin
      serial_clock_oe_q <= 1'b0;
      master_out_oe_q <= 1'b0;
      slave_out_oe_q <= 1'b0;
      core_run_q <= 1'b0;
      tx_hold_q <= 1'b0;
    end else begin
      serial_clock_oe_q <= system_enable & master_select_q & ~fault_hit;
      master_out_oe_q <= system_enable & master_select_q & ~fault_hit & dir_ok;
      // A faulted part is a slave with its outputs off
      slave_out_oe_q <= system_enable & ~master_select_q & ~mode_fault_flag_q
        & ~fault_hit & ~sel_s_q & dir_ok;
      // In doze a slave keeps its clock so it stays in step with the master
      core_run_q <= system_enable & (lp_d == `SFP_LP_RUN
        | (~master_select_q & lp_d == `SFP_LP_DOZE));
      // No new word while paused: slave repeats what it was sending
      tx_hold_q <= (lp_d != `SFP_LP_RUN) | ~system_enable;
    end
  end

  // ----------------------------------------------------------------
  // Receive copy, full and match flags
  // ----------------------------------------------------------------
  wire done_now; // Word finished while fully awake
  wire copy_src; // Some word wants to reach the data register
  wire [DATA_W-1:0] copy_data;
  wire copy_take; // Copy actually made
  wire match_eq;
  reg rx_arm_q;
  reg tx_arm_q;

  assign done_now = shifter_done & system_enable & ~lp_low & ~abort_q;
  assign copy_src = done_now | (lp_exit & defer_q);
  assign copy_data = done_now ? shifter_rx_data : defer_data_q;
  assign copy_take = copy_src & ~rx_full_flag_q;
  // Eight-bit mode compares only the low byte
  assign match_eq = sixteen_bit_mode ? (copy_data == match_value)
    : (copy_data[BYTE_W-1:0] == match_value[BYTE_W-1:0]);

  // Set wins over any clear arriving together
  always @(posedge core_clk) begin
    if (kill) begin
      rx_data_q <= `SFP_RST_DATA;
      rx_full_flag_q <= `SFP_RST_FLAG;
      match_flag_q <= `SFP_RST_FLAG;
      rx_arm_q <= 1'b0;
    end else begin
      if (copy_take) begin
        rx_data_q <= sixteen_bit_mode ? copy_data
          : {{(DATA_W-BYTE_W){1'b0}}, copy_data[BYTE_W-1:0]};
      end
      if (status_rd && rx_full_flag_q) begin
        rx_arm_q <= 1'b1;
      end else if (data_rd) begin
        rx_arm_q <= 1'b0;
      end
      if (copy_take) begin
        rx_full_flag_q <= 1'b1;
      end else if (data_rd && rx_arm_q) begin
        rx_full_flag_q <= 1'b0;
      end
      if (copy_take && match_eq) begin
        match_flag_q <= 1'b1;
      end else if (match_clr) begin
        match_flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit buffer, two entries
  // ----------------------------------------------------------------
  reg [DATA_W-1:0] buf_mem_q [0:`SFP_BUF_DEPTH-1];
  reg wr_ptr_q;
  reg rd_ptr_q;
  reg [1:0] count_q;
  reg [1:0] count_d;
  wire push;
  wire pop;
  wire head_nxt; // Entry that heads the buffer after this edge

  // Engine ready is ignored while held, so a pause loses nothing
  assign push = data_wr & tx_in_ready_q;
  assign pop = tx_out_valid_q & tx_out_ready & ~tx_hold_q;
  assign head_nxt = pop ? ~rd_ptr_q : rd_ptr_q;

  always @* begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 2'd1;
    end else if (pop && !push) begin
      count_d = count_q - 2'd1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `SFP_BUF_DEPTH; gi = gi + 1) begin : g_ent
      // Each entry loads when the write pointer selects it
      always @(posedge core_clk) begin
        if (kill) begin
          buf_mem_q[gi] <= `SFP_RST_DATA;
        end else if (push && wr_ptr_q == gi) begin
          buf_mem_q[gi] <= data_wr_value;
        end
      end
    end
  endgenerate

  // Pointers, count and registered handshake outputs
  always @(posedge core_clk) begin
    if (kill) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'd0;
      tx_in_ready_q <= 1'b1;
      tx_out_valid_q <= 1'b0;
      tx_out_data_q <= `SFP_RST_DATA;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= count_d;
      tx_in_ready_q <= (count_d != 2'd2);
      tx_out_valid_q <= (count_d != 2'd0);
      // A word written into the new head entry is not in storage yet
      if (count_d != 2'd0) begin
        if (push && wr_ptr_q == head_nxt) begin
          tx_out_data_q <= data_wr_value;
        end else begin
          tx_out_data_q <= buf_mem_q[head_nxt];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit empty flag
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (kill) begin
      tx_empty_flag_q <= 1'b1;
      tx_arm_q <= 1'b0;
    end else begin
      if (status_rd && tx_empty_flag_q) begin
        tx_arm_q <= 1'b1;
      end else if (data_wr) begin
        tx_arm_q <= 1'b0;
      end
      if (pop) begin
        tx_empty_flag_q <= 1'b1;
      end else if (data_wr && tx_arm_q) begin
        tx_empty_flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  // Level follows the flags, so clearing a flag drops it
  always @(posedge core_clk) begin
    if (kill) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= system_enable & (((rx_full_flag_q | mode_fault_flag_q) & rx_fault_irq_mask)
        | (tx_empty_flag_q & tx_irq_mask)
        | (match_flag_q & match_irq_mask));
    end
  end

endmodule // sfp_core

// [hw/sfp_regs.vh]
// Constants for the serial port fault, low-power and flag block.
// Assumes inclusion by the single design file of this block.
`ifndef SFP_REGS_VH
`define SFP_REGS_VH

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SFP_RST_FLAG 1'b0
`define SFP_RST_MASTER 1'b0
`define SFP_RST_DATA 16'h0000

// ----------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------
`define SFP_DATA_W 16
`define SFP_BYTE_W 8
`define SFP_BUF_DEPTH 2

// ----------------------------------------------------------------
// Timing: core clock 100 MHz, link clock period in the bench
// ----------------------------------------------------------------
`define SFP_CLK_NS 10
`define SFP_LINK_NS 125

// ----------------------------------------------------------------
// Low-power state encoding, one-hot
// ----------------------------------------------------------------
`define SFP_LP_RUN 3'b001
`define SFP_LP_DOZE 3'b010
`define SFP_LP_FROZEN 3'b100

`endif

// [tb/sfp_checker_properties.sv]
// Checker for the fault, flag and interrupt relations of sfp_core.
// Assumes a bind into sfp_core; it sees only that module's ports.
`timescale 1ns/1ps
module sfp_checker #(
  parameter DATA_W = 16
) (
  // Clock and resets
  input wire core_clk,
  input wire srst,
  input wire cpu_stop_other,
  // Levels and strobes
  input wire system_enable,
  input wire mode_fault_enable,
  input wire select_output_enable,
  input wire sixteen_bit_mode,
  input wire rx_fault_irq_mask,
  input wire tx_irq_mask,
  input wire match_irq_mask,
  input wire [DATA_W-1:0] match_value,
  input wire status_rd,
  input wire ctl1_wr,
  input wire tx_out_ready,
  // Outputs under watch
  input wire mode_fault_flag_q,
  input wire rx_full_flag_q,
  input wire tx_empty_flag_q,
  input wire match_flag_q,
  input wire master_select_q,
  input wire shared_pin_output_enable_q,
  input wire [DATA_W-1:0] rx_data_q,
  input wire irq_q,
  input wire tx_out_valid_q,
  input wire abort_q,
  input wire tx_hold_q,
  input wire serial_clock_oe_q,
  input wire master_out_oe_q,
  input wire slave_out_oe_q
);
  // ----------------------------------------------------------------
  // Helper state and properties
  // ----------------------------------------------------------------
  // Deep stop acts as a reset, so it disables the checks as well
  default clocking chk_cb @(posedge core_clk);
  endclocking
  default disable iff (srst || cpu_stop_other);
  reg irq_src_q; // Some enabled flag and mask pair one cycle ago
  reg pop_q; // Buffer handed a word to the shifter one cycle ago
  // Registered causes, so the interrupt and empty flag have a reason
  always @(posedge core_clk) begin
    irq_src_q <= system_enable && ((rx_fault_irq_mask && (rx_full_flag_q || mode_fault_flag_q))
      || (tx_irq_mask && tx_empty_flag_q) || (match_irq_mask && match_flag_q));
    pop_q <= tx_out_valid_q && tx_out_ready && !tx_hold_q;
  end
  // Status read with the fault set, then a control write
  sequence armed_clear_s;
    status_rd && mode_fault_flag_q ##1 ctl1_wr;
  endsequence
  // The fault appears together with its side effects
  sequence fault_rise_s;
    $rose(mode_fault_flag_q);
  endsequence
  fault_set_a: assert property (
    fault_rise_s |-> $past(master_select_q) && $past(mode_fault_enable)
      && !$past(select_output_enable))
    else $error("mode fault raised outside a detecting master");
  fault_release_a: assert property (
    fault_rise_s |-> !master_select_q && abort_q && !serial_clock_oe_q && !master_out_oe_q
      && !slave_out_oe_q && !shared_pin_output_enable_q)
    else $error("mode fault left the pins or master select driven");
  fault_clear_a: assert property (
    armed_clear_s |=> !mode_fault_flag_q)
    else $error("mode fault survived status read and control write");
  fault_irq_a: assert property (
    mode_fault_flag_q && rx_fault_irq_mask && system_enable |=> irq_q)
    else $error("mode fault with mask set gave no interrupt");
  irq_gate_a: assert property (
    !system_enable |=> !irq_q)
    else $error("interrupt raised while the system is disabled");
  irq_cause_a: assert property (
    irq_q |-> irq_src_q)
    else $error("interrupt without an enabled flag");
  rx_hold_a: assert property (
    rx_full_flag_q |=> $stable(rx_data_q))
    else $error("receive data changed while full");
  tx_empty_a: assert property (
    $rose(tx_empty_flag_q) |-> pop_q)
    else $error("transmit empty set without a word entering the shifter");
  match_value_a: assert property (
    $rose(match_flag_q) |-> (sixteen_bit_mode ? rx_data_q == match_value
      : rx_data_q[7:0] == match_value[7:0]))
    else $error("match flag set on unequal data");
endmodule // sfp_checker

bind sfp_core sfp_checker #(.DATA_W(DATA_W)) u_chk (.*);

// [tb/sfp_partner.sv]
// Remote master model: selects the device and clocks one frame.
// Assumes the bench toggles frame_go once per frame, frames apart.
`timescale 1ns/1ps
module sfp_partner #(
  parameter EDGES = 16
) (
  // Frame request
  input wire frame_go,
  // Pins toward the device
  output reg select_n_pin,
  output reg serial_clock_pin
);
  // ----------------------------------------------------------------
  // Frame generation
  // ----------------------------------------------------------------
  // Link clock stands still and select is high between frames
  initial begin
    select_n_pin = 1'b1;
    serial_clock_pin = 1'b0;
  end
  // One frame at 125 ns period; time zero skipped so reset sees no frame
  always @(frame_go) begin
    if ($time > 0) begin
      select_n_pin = 1'b0;
      repeat (EDGES) begin
        #62.5;
        serial_clock_pin = ~serial_clock_pin;
      end
      #62.5;
      select_n_pin = 1'b1;
    end
  end
endmodule // sfp_partner

// [tb/sfp_core_bench.sv]
// Self-checking bench for sfp_core with a remote master model.
// Assumes sfp_checker is bound in and sfp_partner drives the pins.
`timescale 1ns/1ps
module sfp_core_bench;
  // ----------------------------------------------------------------
  // Signals, model and helpers
  // ----------------------------------------------------------------
  reg core_clk, srst, system_enable, mode_fault_enable, select_output_enable;
  reg single_wire_select, sixteen_bit_mode, stop_in_wait, rx_fault_irq_mask;
  reg tx_irq_mask, match_irq_mask, cpu_wait, cpu_stop3, cpu_stop_other;
  reg ctl1_master_select, ctl2_shared_oe, tx_out_ready, frame_go;
  reg [5:0] stb; // Strobes: status, ctl1, data read, data write, match clear, done
  reg [15:0] match_value, data_wr_value, shifter_rx_data, d;
  wire status_rd, ctl1_wr, data_rd, data_wr, match_clr, shifter_done;
  wire select_n_pin, serial_clock_pin, mode_fault_flag_q, rx_full_flag_q, tx_empty_flag_q;
  wire match_flag_q, master_select_q, shared_pin_output_enable_q, irq_q, tx_in_ready_q;
  wire tx_out_valid_q, core_run_q, abort_q, tx_hold_q, serial_clock_oe_q;
  wire master_out_oe_q, slave_out_oe_q;
  wire [15:0] rx_data_q, tx_out_data_q;
  integer errors, n_tests, i;
  assign {status_rd, ctl1_wr, data_rd, data_wr, match_clr, shifter_done} = stb;
  sfp_core uut (.*);
  sfp_partner far_end (.frame_go(frame_go), .select_n_pin(select_n_pin),
    .serial_clock_pin(serial_clock_pin));
  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Expected receive word: 8-bit mode keeps the low byte only
  function [15:0] rx_expect(input [15:0] w, input m16);
    rx_expect = m16 ? w : {8'h00, w[7:0]};
  endfunction
  task check(input [15:0] seen, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Edges only; reads at an edge see the state settled before it
  task tick(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  // Two strobe words on back-to-back edges, then one edge to land
  task strobe(input [5:0] a, input [5:0] b);
    begin
      @(posedge core_clk);
      stb <= a;
      @(posedge core_clk);
      stb <= b;
      @(posedge core_clk);
      stb <= 6'h00;
      @(posedge core_clk);
    end
  endtask
  task end_sim;
    begin
      $display("comparisons %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // Watchdog: the tests need about 7 us
  initial begin
    #100000;
    errors = errors + 1;
    end_sim;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {mode_fault_enable, select_output_enable, single_wire_select, sixteen_bit_mode} = 4'h0;
    {stop_in_wait, rx_fault_irq_mask, tx_irq_mask, match_irq_mask, cpu_wait} = 5'h00;
    {cpu_stop3, cpu_stop_other, ctl1_master_select, ctl2_shared_oe} = 4'h0;
    {tx_out_ready, frame_go, stb} = 8'h00;
    {match_value, data_wr_value, shifter_rx_data} = 48'h0;
    system_enable = 1'b1;
    srst = 1'b1;
    errors = 0;
    n_tests = 0;
    void'($urandom(94003));
    tick(5);
    srst <= 1'b0;
    tick(2);
    check(rx_data_q, 16'h0000);
    check({mode_fault_flag_q, rx_full_flag_q, tx_empty_flag_q, irq_q}, 4'h2);
    // Receive in slave mode, both sizes, a discarded word, masked interrupt
    for (i = 0; i < 2; i = i + 1) begin
      d = $urandom;
      sixteen_bit_mode <= i[0];
      match_value <= i[0] ? d : {~d[15:8], d[7:0]};
      shifter_rx_data <= d;
      strobe(6'h01, 6'h00);
      check(rx_full_flag_q, 1'b1);
      check(rx_data_q, rx_expect(d, i[0]));
      check(match_flag_q, 1'b1);
      shifter_rx_data <= ~d;
      rx_fault_irq_mask <= 1'b1;
      strobe(6'h01, 6'h00);
      check(rx_data_q, rx_expect(d, i[0]));
      check(irq_q, 1'b1);
      system_enable <= 1'b0;
      tick(2);
      check(irq_q, 1'b0);
      {system_enable, rx_fault_irq_mask} <= 2'b10;
      strobe(6'h20, 6'h08);
      check(rx_full_flag_q, 1'b0);
      strobe(6'h02, 6'h00);
    end
    // Transmit buffer: fill until refused, then drain
    d = $urandom;
    data_wr_value <= d;
    tx_irq_mask <= 1'b1;
    strobe(6'h20, 6'h04);
    check(tx_empty_flag_q, 1'b0);
    data_wr_value <= ~d;
    strobe(6'h04, 6'h04);
    check(tx_in_ready_q, 1'b0);
    check(tx_out_data_q, d);
    tx_out_ready <= 1'b1;
    tick(2);
    check(tx_out_data_q, ~d);
    tick(4);
    check({tx_out_valid_q, tx_empty_flag_q, irq_q}, 3'b011);
    {tx_out_ready, tx_irq_mask} <= 2'b00;
    // Fault detection: plain, detection off, auto select output
    {rx_fault_irq_mask, single_wire_select} <= 2'b11;
    for (i = 0; i < 3; i = i + 1) begin
      mode_fault_enable <= (i != 1);
      select_output_enable <= (i == 2);
      {ctl1_master_select, ctl2_shared_oe} <= 2'b11;
      strobe(6'h10, 6'h00);
      frame_go <= ~frame_go;
      tick(8);
      check(mode_fault_flag_q, i == 0);
      check(master_select_q, i != 0);
      check(irq_q, i == 0);
      if (i == 0)
        check({serial_clock_oe_q, master_out_oe_q, slave_out_oe_q,
          shared_pin_output_enable_q}, 4'h0);
      tick(110);
      strobe(6'h20, 6'h10);
      tick(1);
      check({mode_fault_flag_q, irq_q}, 2'b00);
    end
    {ctl1_master_select, mode_fault_enable, rx_fault_irq_mask} <= 3'b000;
    strobe(6'h10, 6'h00);
    // Slave in wait, then stop3, entered mid-frame: copy waits for exit
    stop_in_wait <= 1'b1;
    for (i = 0; i < 2; i = i + 1) begin
      frame_go <= ~frame_go;
      tick(30);
      {cpu_stop3, cpu_wait} <= i ? 2'b10 : 2'b01;
      d = $urandom;
      shifter_rx_data <= d;
      strobe(6'h01, 6'h00);
      tick(3);
      check(rx_full_flag_q, 1'b0);
      check({core_run_q, tx_hold_q}, {i == 0, 1'b1});
      {cpu_stop3, cpu_wait} <= 2'b00;
      tick(4);
      check(rx_full_flag_q, 1'b1);
      check(rx_data_q, d);
      tick(90);
      strobe(6'h20, 6'h08);
    end
    // Deep stop returns all but the pin synchronisers to reset values
    shifter_rx_data <= 16'ha5c3;
    strobe(6'h01, 6'h00);
    cpu_stop_other <= 1'b1;
    tick(2);
    cpu_stop_other <= 1'b0;
    tick(1);
    check(rx_data_q, 16'h0000);
    check({rx_full_flag_q, tx_empty_flag_q, master_select_q}, 3'b010);
    end_sim;
  end
endmodule // sfp_core_bench
